// ===== hw/tpdic_ctrl.sv
// Pen detection, conversion sequencing and interrupt control
`timescale 1ns/1ps
// Overview of operation
// - Interrupt output is open-drain active low; never driven high.
// - Interrupt raised on pen touch and on new channel data.
// - Hardware reset pin low returns all control logic to reset state except the slave address and resistor select registers.
// - Address-select pin level changes the slave address answered.
// - Interrupt mode only interrupts; trigger mode starts a conversion instead.
// - Wait a quarter of the power-up delay before sampling the comparator.
// - Pen-detect pull-up resistor selectable among four values.
// - Every pen detection sets the pen interrupt flag in status.
// - In interrupt mode a pen detection pulls the interrupt low.
// - Status read clears pen flag and releases the interrupt at once.
// - X and Y are 12-bit codes, full scale 4095 times divider ratio.
// - Two pressure setups z1 and z2 follow X and Y, each own result.
// - Pressure codes z1 and z2 scaled to 4095 times their ratio.
// - Address-select level is the lsb of the 7-bit slave address.
// - Final not-acknowledge of a channel read releases the interrupt.
module tpdic_ctrl
   import tpdic_pkg::*;
#(
   parameter int CODE_W = TPDIC_CODE_W
) (
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hw_reset_in_n,
   // Pins
   input wire logic addr_select_pin,
   input wire logic pen_comparator,
   output logic irq_out_o,
   output logic irq_out_oe,
   // Configuration
   input wire tpdic_cfg_t cfg,
   // Host events from the serial slave
   input wire logic status_read,
   input wire logic chan_read_nack,
   // Converter interface
   output logic pen_bias_en,
   output logic [TPDIC_RPEN_W-1:0] pen_res_sel,
   output logic [TPDIC_RMSEL_W-1:0] rmsel_x,
   output logic [TPDIC_RMSEL_W-1:0] rmsel_y,
   output logic conv_start,
   output logic [2:0] conv_chan,
   input wire logic conv_done,
   input wire logic [CODE_W-1:0] conv_code,
   // Status and results
   output logic [TPDIC_ADDR_W-1:0] slave_addr,
   output logic pen_irq_flag,
   output logic data_ready,
   output tpdic_result_t result
);

   // =====================================================
   // Pin synchronisation
   logic rst_pin_n_s;
   logic addr_sel_s;
   logic pen_cmp_s;
   logic ctl_rst;

   tpdic_sync #(.RESET_VAL(1'b1)) u_sync_rst (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(hw_reset_in_n),
      .dout(rst_pin_n_s)
   );

   tpdic_sync #(.RESET_VAL(1'b0)) u_sync_addr (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(addr_select_pin),
      .dout(addr_sel_s)
   );

   tpdic_sync #(.RESET_VAL(1'b0)) u_sync_pen (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(pen_comparator),
      .dout(pen_cmp_s)
   );

   // pin reset acts as synchronous clear of sequencer, flag, result and interrupt state; slave address and resistor selects keep running
   assign ctl_rst = ~rst_pin_n_s;

   // =====================================================
   // Slave address
   // pin level alters the address
   logic [TPDIC_ADDR_W-1:0] next_slave_addr;
   assign next_slave_addr = {TPDIC_ADDR_UPPER, addr_sel_s};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slave_addr <= {TPDIC_ADDR_UPPER, 1'b0};
      end else begin
         slave_addr <= next_slave_addr;
      end
   end

   // =====================================================
   // Resistor selects passed to the analog side
   // four pull-up values
   // multi-touch selects taken as programmed by the host
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pen_res_sel <= '0;
         rmsel_x <= '0;
         rmsel_y <= '0;
      end else begin
         pen_res_sel <= cfg.pen_detect_res_select;
         rmsel_x <= cfg.multitouch_res_select_x;
         rmsel_y <= cfg.multitouch_res_select_y;
      end
   end

   // =====================================================
   // Bias settling delay
   logic [TPDIC_CNT_W-1:0] bias_cycles;
   logic [TPDIC_CNT_W-1:0] bias_cnt;
   logic [TPDIC_CNT_W-1:0] pwr_cycles;
   // quarter of the power-up delay, never below one cycle
   assign pwr_cycles = TPDIC_CNT_W'((int'(cfg.power_up_delay_setting) + 1)
                                    * TPDIC_PWR_STEP_CYC);
   assign bias_cycles = ((pwr_cycles >> TPDIC_BIAS_SHIFT) == '0) ? TPDIC_CNT_W'(1)
                        : (pwr_cycles >> TPDIC_BIAS_SHIFT);

   // =====================================================
   // Sequencer
   tpdic_state_t state;
   tpdic_state_t next_state;
   logic bias_done;
   logic pen_seen;
   logic trig_mode;
   logic last_chan;
   logic [2:0] next_chan;

   assign bias_done = (bias_cnt == bias_cycles);
   // Trigger mode takes priority if both modes are set
   assign trig_mode = cfg.pen_trigger_mode;
   assign pen_seen = (state == TPDIC_SAMPLE) && pen_cmp_s;
   assign last_chan = (conv_chan == TPDIC_CH_LAST);
   assign next_chan = last_chan ? TPDIC_CH_X : conv_chan + 3'h1;

   always_comb begin
      next_state = state;
      unique case (state)
         TPDIC_IDLE: begin
            if (cfg.pen_interrupt_mode || cfg.pen_trigger_mode) begin
               next_state = TPDIC_BIAS;
            end
         end
         TPDIC_BIAS: begin
            if (bias_done) begin
               next_state = TPDIC_SAMPLE;
            end
         end
         TPDIC_SAMPLE: begin
            // trigger mode converts, interrupt mode only flags
            if (pen_cmp_s && trig_mode) begin
               next_state = TPDIC_CONVERT;
            end else if (pen_cmp_s) begin
               next_state = TPDIC_HOLD;
            end else begin
               next_state = TPDIC_IDLE;
            end
         end
         TPDIC_CONVERT: begin
            if (conv_done && last_chan) begin
               next_state = TPDIC_HOLD;
            end
         end
         TPDIC_HOLD: begin
            // Wait for pen lift so one touch gives one event
            if (!pen_cmp_s) begin
               next_state = TPDIC_IDLE;
            end
         end
         default: next_state = TPDIC_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= TPDIC_IDLE;
      end else if (ctl_rst) begin
         state <= TPDIC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bias_cnt <= '0;
      end else if (ctl_rst || state != TPDIC_BIAS) begin
         bias_cnt <= '0;
      end else begin
         bias_cnt <= bias_cnt + TPDIC_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pen_bias_en <= 1'b0;
      end else begin
         pen_bias_en <= ~ctl_rst && (next_state == TPDIC_BIAS || next_state == TPDIC_SAMPLE);
      end
   end

   // =====================================================
   // Conversion channel walk: X, Y, then pressure z1, z2
   logic enter_conv;
   assign enter_conv = (state == TPDIC_SAMPLE) && (next_state == TPDIC_CONVERT);

   // two pressure setups after X and Y
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_chan <= TPDIC_CH_X;
         conv_start <= 1'b0;
      end else if (ctl_rst) begin
         conv_chan <= TPDIC_CH_X;
         conv_start <= 1'b0;
      end else begin
         conv_start <= enter_conv || (state == TPDIC_CONVERT && conv_done && !last_chan);
         if (state == TPDIC_CONVERT && conv_done) begin
            conv_chan <= next_chan;
         end
      end
   end

   // position codes kept at full 12-bit scale
   // pressure codes kept the same way
   logic [TPDIC_CODE_W-1:0] sat_code;
   assign sat_code = (conv_code > CODE_W'(TPDIC_FULL_SCALE)) ? TPDIC_FULL_SCALE
                     : TPDIC_CODE_W'(conv_code);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result <= '0;
      end else if (ctl_rst) begin
         result <= '0;
      end else begin
         result.valid <= (state == TPDIC_CONVERT) && conv_done;
         if (state == TPDIC_CONVERT && conv_done) begin
            result.chan <= conv_chan;
            result.code <= sat_code;
         end
      end
   end

   // =====================================================
   // Flags and interrupt
   logic data_set;
   logic pen_irq_set;
   assign data_set = (state == TPDIC_CONVERT) && conv_done && last_chan;
   assign pen_irq_set = pen_seen;

   // Set wins over a same-cycle clear
   // status read clears the flag
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pen_irq_flag <= 1'b0;
      end else if (ctl_rst) begin
         pen_irq_flag <= 1'b0;
      end else if (pen_irq_set) begin
         pen_irq_flag <= 1'b1;
      end else if (status_read) begin
         pen_irq_flag <= 1'b0;
      end
   end

   // channel read nack clears data pending
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_ready <= 1'b0;
      end else if (ctl_rst) begin
         data_ready <= 1'b0;
      end else if (data_set) begin
         data_ready <= 1'b1;
      end else if (chan_read_nack) begin
         data_ready <= 1'b0;
      end
   end

   // pen and data events both request
   // pen pulls low only in interrupt mode
   logic irq_pend;
   logic next_pen_flag;
   logic next_data_ready;
   assign next_pen_flag = pen_irq_set || (pen_irq_flag && !status_read);
   assign next_data_ready = data_set || (data_ready && !chan_read_nack);
   // Follow next flag values so a clear of one source never drops the other
   assign irq_pend = (next_pen_flag && cfg.pen_interrupt_mode && !cfg.pen_trigger_mode)
                     || next_data_ready;

   // output level fixed low, only the enable moves
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_out_o <= 1'b0;
         irq_out_oe <= 1'b0;
      end else if (ctl_rst) begin
         irq_out_o <= 1'b0;
         irq_out_oe <= 1'b0;
      end else begin
         irq_out_o <= 1'b0;
         irq_out_oe <= irq_pend;
      end
   end

endmodule : tpdic_ctrl

// ===== hw/tpdic_pkg.sv
// Shared constants and types for the pen-detect and interrupt controller
package tpdic_pkg;

   // Slave address: upper six bits fixed, pin level supplies the lsb
   localparam logic [5:0] TPDIC_ADDR_UPPER = 6'h24;
   localparam int TPDIC_ADDR_W = 7;

   // Code scaling
   localparam int TPDIC_CODE_W = 12;
   localparam logic [11:0] TPDIC_FULL_SCALE = 12'hFFF;

   // Power-up delay setting width and the unit one step stands for
   localparam int TPDIC_PWR_DLY_W = 4;
   localparam int TPDIC_CLK_MHZ = 100;
   localparam int TPDIC_PWR_STEP_NS = 500;
   localparam int TPDIC_PWR_STEP_CYC = (TPDIC_PWR_STEP_NS * TPDIC_CLK_MHZ + 999) / 1000;
   // Bias settling is a quarter of the power-up delay
   localparam int TPDIC_BIAS_SHIFT = 2;
   localparam int TPDIC_CNT_W = 16;

   // Pen-detect resistor and multi-touch resistor select widths
   localparam int TPDIC_RPEN_W = 2;
   localparam int TPDIC_RMSEL_W = 3;

   // Channel identifiers, in read order
   localparam logic [2:0] TPDIC_CH_X = 3'h0;
   localparam logic [2:0] TPDIC_CH_Y = 3'h1;
   localparam logic [2:0] TPDIC_CH_Z1 = 3'h2;
   localparam logic [2:0] TPDIC_CH_Z2 = 3'h3;
   localparam logic [2:0] TPDIC_CH_LAST = 3'h3;

   typedef enum logic [4:0] {
      TPDIC_IDLE = 5'h01,
      TPDIC_BIAS = 5'h02,
      TPDIC_SAMPLE = 5'h04,
      TPDIC_CONVERT = 5'h08,
      TPDIC_HOLD = 5'h10
   } tpdic_state_t;

   // Configuration from host registers
   typedef struct packed {
      logic pen_interrupt_mode;
      logic pen_trigger_mode;
      logic [3:0] power_up_delay_setting;
      logic [1:0] pen_detect_res_select;
      logic [2:0] multitouch_res_select_x;
      logic [2:0] multitouch_res_select_y;
   } tpdic_cfg_t;

   // One channel result from the converter
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [11:0] code;
   } tpdic_result_t;

endpackage : tpdic_pkg

// ===== hw/tpdic_sync.sv
// Two-stage synchroniser for a single pin level
`timescale 1ns/1ps
module tpdic_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Level in and out
   input wire logic din,
   output logic dout
);
   logic stage1;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule : tpdic_sync

// ===== verif/tpdic_ctrl_checker.sv
// Concurrent checks on the pen-detect and interrupt controller ports
`timescale 1ns/1ps
module tpdic_ctrl_checker
   import tpdic_pkg::*;
#(
   parameter int CODE_W = TPDIC_CODE_W
) (
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hw_reset_in_n,
   // Pins
   input wire logic addr_select_pin,
   input wire logic pen_comparator,
   input wire logic irq_out_o,
   input wire logic irq_out_oe,
   // Configuration and host events
   input wire tpdic_cfg_t cfg,
   input wire logic status_read,
   input wire logic chan_read_nack,
   // Converter
   input wire logic pen_bias_en,
   input wire logic [TPDIC_RPEN_W-1:0] pen_res_sel,
   input wire logic [TPDIC_RMSEL_W-1:0] rmsel_x,
   input wire logic [TPDIC_RMSEL_W-1:0] rmsel_y,
   input wire logic conv_start,
   input wire logic [2:0] conv_chan,
   input wire logic conv_done,
   input wire logic [CODE_W-1:0] conv_code,
   // Status and results
   input wire logic [TPDIC_ADDR_W-1:0] slave_addr,
   input wire logic pen_irq_flag,
   input wire logic data_ready,
   input wire tpdic_result_t result
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Bias window length
   logic [15:0] bias_cnt;
   logic [15:0] bias_w;
   assign bias_w = 16'(((int'(cfg.power_up_delay_setting) + 1) * TPDIC_PWR_STEP_CYC)
                       >> TPDIC_BIAS_SHIFT);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bias_cnt <= 16'h0;
      end else begin
         bias_cnt <= pen_bias_en ? bias_cnt + 16'h1 : 16'h0;
      end
   end
   sequence s_trig_start;
      !irq_out_oe ##[0:1] conv_start;
   endsequence
   // Pin level must survive two sync stages and a hardware reset release
   sequence s_pin_steady;
      (hw_reset_in_n && $stable(addr_select_pin)) [*8];
   endsequence
   // ==========
   // Assertions
   chk_od_never_high: assert property (irq_out_oe |-> !irq_out_o)
      else $error("interrupt pin driven high");
   chk_idle_released: assert property (!pen_irq_flag && !data_ready |-> !irq_out_oe)
      else $error("interrupt held with nothing pending");
   chk_pen_irq_low: assert property ($rose(pen_irq_flag) && cfg.pen_interrupt_mode
      && !cfg.pen_trigger_mode |-> irq_out_oe) else $error("pen event left irq high");
   chk_trig_conv: assert property ($rose(pen_irq_flag) && cfg.pen_trigger_mode
      && !data_ready |-> s_trig_start) else $error("trigger mode pen event wrong");
   chk_flag_clear: assert property (status_read && !pen_bias_en |=> !pen_irq_flag)
      else $error("status read left pen flag set");
   chk_nack_release: assert property (chan_read_nack && !pen_irq_flag && !conv_done
      |=> !data_ready && !irq_out_oe) else $error("final nack kept irq");
   chk_addr_lsb: assert property (s_pin_steady
      |-> slave_addr == {TPDIC_ADDR_UPPER, addr_select_pin}) else $error("slave address wrong");
   chk_bias_quarter: assert property ($fell(pen_bias_en) && hw_reset_in_n
      |-> bias_cnt > bias_w && bias_cnt <= bias_w + 16'h2) else $error("bias wait wrong");
endmodule : tpdic_ctrl_checker

bind tpdic_ctrl tpdic_ctrl_checker #(.CODE_W(CODE_W)) u_tpdic_ctrl_checker (.*);

// ===== verif/tpdic_ctrl_tb_top.sv
// Self-checking bench for the pen-detect and interrupt controller
`timescale 1ns/1ps
module tpdic_ctrl_tb_top
   import tpdic_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hw_reset_in_n = 1'b1;
   logic addr_select_pin = 1'b0;
   logic pen_comparator = 1'b0;
   logic rd_stat = 1'b0;
   logic rd_chan = 1'b0;
   tpdic_cfg_t cfg = '0;
   logic irq_out_o, irq_out_oe, irq_line, status_read, chan_read_nack, pen_bias_en;
   logic conv_start, conv_done, pen_irq_flag, data_ready;
   logic [1:0] pen_res_sel;
   logic [2:0] rmsel_x, rmsel_y, conv_chan;
   logic [11:0] conv_code;
   logic [6:0] slave_addr;
   tpdic_result_t result;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   tpdic_ctrl u_tpdic_ctrl (.*);
   tpdic_far_model u_tpdic_far_model (.*);
   // ==========
   // Helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // ==========
   // Scenarios
   task automatic t_addr();
      int i;
      for (i = 1; i >= 0; i--) begin
         tick(1);
         addr_select_pin <= i[0];
         tick(4);
         @(negedge clk);
         check("addr", slave_addr, {TPDIC_ADDR_UPPER, i[0]});
      end
      $display("addr done");
   endtask : t_addr
   task automatic t_cfg();
      int i;
      for (i = 0; i < 8; i++) begin
         tick(1);
         cfg.pen_detect_res_select <= i[1:0];
         cfg.multitouch_res_select_x <= i[2:0];
         cfg.multitouch_res_select_y <= ~i[2:0];
         tick(1);
         @(negedge clk);
         check("pen res", pen_res_sel, i[1:0]);
         check("mt res", {rmsel_x, rmsel_y}, {i[2:0], ~i[2:0]});
      end
      $display("cfg done");
   endtask : t_cfg
   task automatic t_pen(input logic [3:0] dly, input logic hw);
      int i;
      tick(1);
      cfg.power_up_delay_setting <= dly;
      cfg.pen_interrupt_mode <= 1'b1;
      pen_comparator <= 1'b1;
      for (i = 0; i < 300 && pen_irq_flag !== 1'b1; i++) @(negedge clk);
      check("pen flag", pen_irq_flag, 1'b1);
      check("irq low", irq_line, 1'b0);
      check("no conv", conv_start, 1'b0);
      tick(1);
      cfg.pen_interrupt_mode <= 1'b0;
      pen_comparator <= 1'b0;
      rd_stat <= !hw;
      hw_reset_in_n <= !hw;
      tick(1);
      rd_stat <= 1'b0;
      tick(4);
      @(negedge clk);
      check("flag clr", pen_irq_flag, 1'b0);
      check("irq rel", irq_line, 1'b1);
      tick(1);
      hw_reset_in_n <= 1'b1;
      tick(8);
      $display("pen done");
   endtask : t_pen
   task automatic t_trig();
      int i;
      int k;
      tick(1);
      cfg.power_up_delay_setting <= 4'h0;
      cfg.pen_interrupt_mode <= 1'b1;
      cfg.pen_trigger_mode <= 1'b1;
      pen_comparator <= 1'b1;
      for (k = 0; k < 4; k++) begin
         for (i = 0; i < 300 && result.valid !== 1'b1; i++) @(negedge clk);
         if (k == 0) check("trig irq", irq_line, 1'b1);
         check("chan", result.chan, 3'(k));
         check("code", result.code, k == 3 ? TPDIC_FULL_SCALE : {3'(k), 9'h155});
         @(negedge clk);
      end
      for (i = 0; i < 4 && data_ready !== 1'b1; i++) @(negedge clk);
      check("data irq", irq_line, 1'b0);
      tick(1);
      cfg.pen_interrupt_mode <= 1'b0;
      cfg.pen_trigger_mode <= 1'b0;
      pen_comparator <= 1'b0;
      rd_stat <= 1'b1;
      tick(1);
      rd_stat <= 1'b0;
      rd_chan <= 1'b1;
      tick(1);
      rd_chan <= 1'b0;
      tick(2);
      @(negedge clk);
      check("ready clr", data_ready, 1'b0);
      check("irq rel", irq_line, 1'b1);
      $display("trig done");
   endtask : t_trig
   // ==========
   // Main sequence and hang guard
   initial begin
      tick(2);
      sys_rst <= 1'b0;
      @(negedge clk);
      check("rst addr", slave_addr, 7'h48);
      check("rst irq", irq_line, 1'b1);
      tick(3);
      t_addr();
      t_cfg();
      t_pen(4'h0, 1'b0);
      t_pen(4'hF, 1'b0);
      t_trig();
      t_pen(4'h3, 1'b1);
      tally_and_finish();
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
endmodule : tpdic_ctrl_tb_top

// ===== verif/tpdic_far_model.sv
// Far-side model: host requests, interrupt pull-up and converter answers
`timescale 1ns/1ps
module tpdic_far_model
   import tpdic_pkg::*;
(
   // Clock
   input wire logic clk,
   // Host side
   input wire logic irq_out_o,
   input wire logic irq_out_oe,
   input wire logic rd_stat,
   input wire logic rd_chan,
   output logic irq_line,
   output logic status_read,
   output logic chan_read_nack,
   // Converter side
   input wire logic conv_start,
   input wire logic [2:0] conv_chan,
   output logic conv_done,
   output logic [11:0] conv_code
);
   logic [3:0] busy;
   logic [2:0] ch;
   assign irq_line = irq_out_oe ? irq_out_o : 1'b1;
   initial begin
      busy = 4'h0;
      status_read = 1'b0;
      chan_read_nack = 1'b0;
      conv_done = 1'b0;
      conv_code = 12'h0;
   end
   always @(posedge clk) begin
      status_read <= rd_stat;
      chan_read_nack <= rd_chan;
      conv_done <= busy == 4'h1;
      // Code is only valid with done; otherwise it toggles
      conv_code <= busy != 4'h1 ? ~conv_code : ch == TPDIC_CH_Z2 ? TPDIC_FULL_SCALE : {ch, 9'h155};
      if (conv_start) begin
         ch <= conv_chan;
         busy <= 4'h5;
      end else if (busy != 4'h0) begin
         busy <= busy - 4'h1;
      end
   end
endmodule : tpdic_far_model
